// ---- cpu_core_pkg.sv ----
// Purpose: shared constants and types of the instruction execution core
// Assumes: program memory presents three bytes at the fetch address
// Notes: opcode groups are decoded by high nibble where the map allows
`default_nettype none
package cpu_core_pkg;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_SP = 8'h07;
  // special function register addresses
  localparam logic [7:0] SFR_SP = 8'h81;
  localparam logic [7:0] SFR_DPL = 8'h82;
  localparam logic [7:0] SFR_DPH = 8'h83;
  localparam logic [7:0] SFR_PSW = 8'hd0;
  localparam logic [7:0] SFR_ACC = 8'he0;
  localparam logic [7:0] SFR_B = 8'hf0;
  // status word bit positions
  localparam int PSW_CY = 7;
  localparam int PSW_AC = 6;
  localparam int PSW_RS1 = 4;
  localparam int PSW_RS0 = 3;
  localparam int PSW_OV = 2;
  localparam int PSW_P = 0;
  // opcode groups by high nibble, operand form by low nibble
  localparam logic [3:0] OPH_ADD = 4'h2;
  localparam logic [3:0] OPH_ADDC = 4'h3;
  localparam logic [3:0] OPH_SUBB = 4'h9;
  localparam logic [3:0] OPH_LD_A = 4'he;
  localparam logic [3:0] OPH_ST_A = 4'hf;
  localparam logic [3:0] OPH_LD_DIR = 4'ha;
  localparam logic [3:0] OPH_LD_IMM = 4'h7;
  localparam logic [3:0] OPH_ST_DIR = 4'h8;
  localparam logic [3:0] LO_IMM = 4'h4;
  localparam logic [3:0] LO_DIR = 4'h5;
  localparam logic [3:0] LO_IND = 4'h6;
  // single opcodes
  localparam logic [7:0] OP_INC_A = 8'h04;
  localparam logic [7:0] OP_CLR_A = 8'he4;
  localparam logic [7:0] OP_MOV_A_IMM = 8'h74;
  localparam logic [7:0] OP_MOV_D_A = 8'hf5;
  localparam logic [7:0] OP_MOV_D_IMM = 8'h75;
  localparam logic [7:0] OP_MOV_D_D = 8'h85;
  localparam logic [7:0] OP_MOV_PTR_IMM = 8'h90;
  localparam logic [7:0] OP_INC_PTR = 8'ha3;
  localparam logic [7:0] OP_DA = 8'hd4;
  localparam logic [7:0] OP_MUL = 8'ha4;
  localparam logic [7:0] OP_MOVX_RD = 8'he0;
  localparam logic [7:0] OP_MOVX_WR = 8'hf0;
  localparam logic [7:0] OP_MOVC_PTR = 8'h93;
  localparam logic [7:0] OP_MOVC_PC = 8'h83;
  localparam logic [7:0] OP_SJMP = 8'h80;
  localparam logic [7:0] OP_JZ = 8'h60;
  localparam logic [7:0] OP_JNZ = 8'h70;
  localparam logic [7:0] OP_JC = 8'h40;
  localparam logic [7:0] OP_JNC = 8'h50;
  localparam logic [7:0] OP_LJMP = 8'h02;
  // cycle counts and decimal adjust constants
  localparam logic [3:0] CYC_ONE = 4'h1;
  localparam logic [3:0] CYC_TWO = 4'h2;
  localparam logic [3:0] CYC_MUL = 4'h4;
  localparam logic [3:0] MOVX_BASE_CYC = 4'h2;
  localparam logic [7:0] DA_LO = 8'h06;
  localparam logic [7:0] DA_HI = 8'h60;
  localparam logic [3:0] BCD_MAX = 4'h9;

  typedef struct packed {
    logic cy;
    logic ac;
    logic ov;
  } flags_t;
  typedef enum logic [1:0] {ALU_ADD, ALU_SUB, ALU_DA} alu_op_t;
  typedef enum logic [1:0] {ST_EXEC = 2'b00, ST_WAIT = 2'b01} state_t;
  typedef enum logic [1:0] {
    PEND_NONE = 2'b00, PEND_XRD = 2'b01, PEND_XWR = 2'b11, PEND_TBL = 2'b10
  } pend_t;

  // instruction length in bytes from the opcode alone
  function automatic logic [1:0] insn_len(input logic [7:0] op);
    logic [3:0] hi;
    logic [3:0] lo;
    hi = op[7:4];
    lo = op[3:0];
    insn_len = 2'd1;
    case (op) inside
      8'h02, 8'h10, 8'h12, 8'h20, 8'h30, 8'h43, 8'h53, 8'h63, 8'h75,
      8'h85, 8'h90, [8'hb4:8'hbf], 8'hd5: insn_len = 2'd3;
      8'h40, 8'h50, 8'h60, 8'h70, 8'h80, 8'ha0, 8'hb0, 8'hc0, 8'hd0,
      8'h42, 8'h52, 8'h62, 8'h72, 8'h82, 8'h92, 8'ha2, 8'hb2, 8'hc2,
      8'hd2, 8'h24, 8'h34, 8'h44, 8'h54, 8'h64, 8'h74, 8'h94, 8'h05,
      8'h15, 8'h25, 8'h35, 8'h45, 8'h55, 8'h65, 8'h95, 8'hc5, 8'he5,
      8'hf5, [8'h76:8'h7f], [8'h86:8'h8f], [8'ha6:8'haf],
      [8'hd8:8'hdf]: insn_len = 2'd2;
      // every x1 opcode is an absolute jump or call with one address byte
      default: insn_len = (lo == 4'h1 && hi <= 4'hf) ? 2'd2 : 2'd1;
    endcase
  endfunction
endpackage
`default_nettype wire

// ---- alu_unit.sv ----
// Purpose: add, subtract with borrow and decimal adjust with flags
// Assumes: purely combinational, driven by the core's decode
// Notes: overflow is left as given for decimal adjust
`default_nettype none
module alu_unit (
  // operation and operands
  input wire cpu_core_pkg::alu_op_t op,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic cin,
  input wire cpu_core_pkg::flags_t fin,
  // result
  output logic [7:0] res,
  output cpu_core_pkg::flags_t fout
);
  logic [8:0] full;
  logic [4:0] half;
  logic [8:0] step;

  always_comb begin
    fout = fin;
    full = 9'h000;
    half = 5'h00;
    step = 9'h000;
    res = a;
    case (op)
      cpu_core_pkg::ALU_ADD: begin
        full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        half = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        res = full[7:0];
        fout.cy = full[8];
        fout.ac = half[4];
        fout.ov = (a[7] == b[7]) && (full[7] != a[7]);
      end
      cpu_core_pkg::ALU_SUB: begin
        full = {1'b0, a} - {1'b0, b} - {8'h00, cin};
        half = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
        res = full[7:0];
        fout.cy = full[8];
        fout.ac = half[4];
        fout.ov = (a[7] != b[7]) && (full[7] != a[7]);
      end
      cpu_core_pkg::ALU_DA: begin
        step = {1'b0, a};
        if (a[3:0] > cpu_core_pkg::BCD_MAX || fin.ac) begin
          step = {1'b0, a} + {1'b0, cpu_core_pkg::DA_LO};
          fout.ac = 1'b1;
        end
        // carry out of the low step also forces the high correction
        if (step[7:4] > cpu_core_pkg::BCD_MAX || fin.cy || step[8]) begin
          full = {1'b0, step[7:0]} + {1'b0, cpu_core_pkg::DA_HI};
        end else begin
          full = {1'b0, step[7:0]};
        end
        res = full[7:0];
        fout.cy = fin.cy | step[8] | full[8];
      end
      default: res = a;
    endcase
  end
endmodule
`default_nettype wire

// ---- cpu_core.sv ----
// Purpose: fetch, decode and execute core for a byte-coded instruction set
// Assumes: code_byte0..2 show program bytes at code_addr..code_addr+2
// Notes: effects commit in the first cycle, later cycles only stall, except external and table accesses, which complete in the last stalled cycle
`default_nettype none
module cpu_core (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // program memory fetch window
  output logic [15:0] code_addr,
  input wire logic [7:0] code_byte0,
  input wire logic [7:0] code_byte1,
  input wire logic [7:0] code_byte2,
  // table lookup read of program memory
  output logic [15:0] tbl_addr,
  input wire logic [7:0] tbl_data,
  // external data memory
  output logic [15:0] xd_addr,
  output logic [7:0] xd_wdata,
  output logic xd_we,
  output logic xd_re,
  input wire logic [7:0] xd_rdata,
  input wire logic [2:0] external_access_timing_field,
  // status
  output logic insn_start,
  output logic [7:0] acc_value,
  output logic [7:0] psw_value
);
  logic [7:0] iram [0:255];
  cpu_core_pkg::state_t state_q, state_d;
  cpu_core_pkg::pend_t pend_q, pend_d;
  logic [15:0] pc_q, pc_d, data_pointer_pair_q, data_pointer_pair_d, tbl_q, tbl_d, nxt_pc;
  logic [7:0] acc_q, acc_d, b_q, b_d, sp_q, sp_d;
  logic [1:0] rs_q, rs_d;
  cpu_core_pkg::flags_t fl_q, fl_d, alu_fl;
  logic [3:0] cnt_q, cnt_d, cyc;
  logic mw_en, mw_dir;
  logic [7:0] mw_addr, mw_val, ab, alu_res, op, b1, b2;
  logic [15:0] prod, rel_ext;
  cpu_core_pkg::alu_op_t aop;
  logic acin;

  assign op = code_byte0;
  assign b1 = code_byte1;
  assign b2 = code_byte2;
  assign rel_ext = {{8{b1[7]}}, b1};
  assign prod = {8'h00, acc_q} * {8'h00, b_q};

  function automatic logic [7:0] reg_addr(input logic [2:0] n);
    reg_addr = {3'h0, rs_q, n};
  endfunction

  // low nibble 6/7 is @R0/@R1, 8..f is R0..R7
  function automatic logic [7:0] ind_tgt(input logic [3:0] lo);
    ind_tgt = lo[3] ? reg_addr(lo[2:0]) : iram[reg_addr({2'b00, lo[0]})];
  endfunction

  function automatic logic [7:0] psw_word();
    psw_word = {fl_q.cy, fl_q.ac, 1'b0, rs_q, fl_q.ov, 1'b0, ^acc_q};
  endfunction

  // unmodelled special registers read as zero
  function automatic logic [7:0] rd_dir(input logic [7:0] a);
    case (a)
      cpu_core_pkg::SFR_ACC: rd_dir = acc_q;
      cpu_core_pkg::SFR_B: rd_dir = b_q;
      cpu_core_pkg::SFR_SP: rd_dir = sp_q;
      cpu_core_pkg::SFR_DPL: rd_dir = data_pointer_pair_q[7:0];
      cpu_core_pkg::SFR_DPH: rd_dir = data_pointer_pair_q[15:8];
      cpu_core_pkg::SFR_PSW: rd_dir = psw_word();
      default: rd_dir = a[7] ? 8'h00 : iram[a];
    endcase
  endfunction

  function automatic logic [7:0] src_val(input logic [3:0] lo);
    if (lo == cpu_core_pkg::LO_IMM) begin
      src_val = b1;
    end else if (lo == cpu_core_pkg::LO_DIR) begin
      src_val = rd_dir(b1);
    end else begin
      src_val = iram[ind_tgt(lo)];
    end
  endfunction

  alu_unit u_alu (
    .op(aop),
    .a(acc_q),
    .b(ab),
    .cin(acin),
    .fin(fl_q),
    .res(alu_res),
    .fout(alu_fl)
  );

  always_comb begin
    state_d = state_q;
    pend_d = pend_q;
    pc_d = pc_q;
    data_pointer_pair_d = data_pointer_pair_q;
    tbl_d = tbl_q;
    acc_d = acc_q;
    b_d = b_q;
    sp_d = sp_q;
    rs_d = rs_q;
    fl_d = fl_q;
    cnt_d = cnt_q;
    mw_en = 1'b0;
    mw_dir = 1'b1;
    mw_addr = b1;
    mw_val = acc_q;
    aop = cpu_core_pkg::ALU_ADD;
    ab = src_val(op[3:0]);
    acin = 1'b0;
    xd_we = 1'b0;
    xd_re = 1'b0;
    cyc = cpu_core_pkg::CYC_ONE;
    nxt_pc = pc_q + {14'h0000, cpu_core_pkg::insn_len(op)};
    if (state_q == cpu_core_pkg::ST_EXEC) begin
      pc_d = nxt_pc;
      pend_d = cpu_core_pkg::PEND_NONE;
      if (op[3:0] >= cpu_core_pkg::LO_IMM &&
          (op[7:4] == cpu_core_pkg::OPH_ADD ||
           op[7:4] == cpu_core_pkg::OPH_ADDC ||
           op[7:4] == cpu_core_pkg::OPH_SUBB)) begin
        if (op[7:4] == cpu_core_pkg::OPH_SUBB) begin
          aop = cpu_core_pkg::ALU_SUB;
        end
        acin = (op[7:4] != cpu_core_pkg::OPH_ADD) && fl_q.cy;
        acc_d = alu_res;
        fl_d = alu_fl;
      end else if (op[7:4] == cpu_core_pkg::OPH_LD_A &&
                   op[3:0] >= cpu_core_pkg::LO_DIR) begin
        acc_d = ab;
      end else if (op[7:4] == cpu_core_pkg::OPH_ST_A &&
                   op[3:0] >= cpu_core_pkg::LO_IND) begin
        mw_en = 1'b1;
        mw_dir = 1'b0;
        mw_addr = ind_tgt(op[3:0]);
      end else if (op[7:4] == cpu_core_pkg::OPH_LD_DIR &&
                   op[3:0] >= cpu_core_pkg::LO_IND) begin
        mw_en = 1'b1;
        mw_dir = 1'b0;
        mw_addr = ind_tgt(op[3:0]);
        mw_val = rd_dir(b1);
        cyc = cpu_core_pkg::CYC_TWO;
      end else if (op[7:4] == cpu_core_pkg::OPH_LD_IMM &&
                   op[3:0] >= cpu_core_pkg::LO_IND) begin
        mw_en = 1'b1;
        mw_dir = 1'b0;
        mw_addr = ind_tgt(op[3:0]);
        mw_val = b1;
      end else if (op[7:4] == cpu_core_pkg::OPH_ST_DIR &&
                   op[3:0] >= cpu_core_pkg::LO_IND) begin
        mw_en = 1'b1;
        mw_val = ab;
        cyc = cpu_core_pkg::CYC_TWO;
      end else begin
        case (op)
          cpu_core_pkg::OP_INC_A: acc_d = acc_q + 8'h01;
          cpu_core_pkg::OP_CLR_A: acc_d = 8'h00;
          cpu_core_pkg::OP_MOV_A_IMM: acc_d = b1;
          cpu_core_pkg::OP_MOV_D_A: mw_en = 1'b1;
          cpu_core_pkg::OP_MOV_D_IMM: begin
            mw_en = 1'b1;
            mw_val = b2;
            cyc = cpu_core_pkg::CYC_TWO;
          end
          cpu_core_pkg::OP_MOV_D_D: begin
            mw_en = 1'b1;
            mw_addr = b2;
            mw_val = rd_dir(b1);
            cyc = cpu_core_pkg::CYC_TWO;
          end
          cpu_core_pkg::OP_MOV_PTR_IMM: begin
            data_pointer_pair_d = {b1, b2};
            cyc = cpu_core_pkg::CYC_TWO;
          end
          cpu_core_pkg::OP_INC_PTR: begin
            data_pointer_pair_d = data_pointer_pair_q + 16'h0001;
            cyc = cpu_core_pkg::CYC_TWO;
          end
          cpu_core_pkg::OP_DA: begin
            aop = cpu_core_pkg::ALU_DA;
            acc_d = alu_res;
            fl_d.cy = alu_fl.cy;
            fl_d.ac = alu_fl.ac;
          end
          cpu_core_pkg::OP_MUL: begin
            acc_d = prod[7:0];
            b_d = prod[15:8];
            fl_d.cy = 1'b0;
            fl_d.ov = |prod[15:8];
            cyc = cpu_core_pkg::CYC_MUL;
          end
          cpu_core_pkg::OP_MOVX_RD, cpu_core_pkg::OP_MOVX_WR: begin
            pend_d = (op == cpu_core_pkg::OP_MOVX_RD) ?
                     cpu_core_pkg::PEND_XRD : cpu_core_pkg::PEND_XWR;
            cyc = cpu_core_pkg::MOVX_BASE_CYC +
                  {1'b0, external_access_timing_field};
          end
          cpu_core_pkg::OP_MOVC_PTR, cpu_core_pkg::OP_MOVC_PC: begin
            tbl_d = {8'h00, acc_q} +
                    ((op == cpu_core_pkg::OP_MOVC_PC) ? nxt_pc : data_pointer_pair_q);
            pend_d = cpu_core_pkg::PEND_TBL;
            cyc = cpu_core_pkg::CYC_TWO;
          end
          cpu_core_pkg::OP_SJMP, cpu_core_pkg::OP_JZ, cpu_core_pkg::OP_JNZ,
          cpu_core_pkg::OP_JC, cpu_core_pkg::OP_JNC: begin
            cyc = cpu_core_pkg::CYC_TWO;
            if (op == cpu_core_pkg::OP_SJMP ||
                (op == cpu_core_pkg::OP_JZ && acc_q == 8'h00) ||
                (op == cpu_core_pkg::OP_JNZ && acc_q != 8'h00) ||
                (op == cpu_core_pkg::OP_JC && fl_q.cy) ||
                (op == cpu_core_pkg::OP_JNC && !fl_q.cy)) begin
              pc_d = nxt_pc + rel_ext;
            end
          end
          cpu_core_pkg::OP_LJMP: begin
            pc_d = {b1, b2};
            cyc = cpu_core_pkg::CYC_TWO;
          end
          default: pc_d = nxt_pc;
        endcase
      end
      if (cyc > cpu_core_pkg::CYC_ONE) begin
        state_d = cpu_core_pkg::ST_WAIT;
        cnt_d = cyc - cpu_core_pkg::CYC_ONE;
      end
    end else begin
      cnt_d = cnt_q - 4'h1;
      // the partner answers in the last stalled cycle
      if (cnt_q == 4'h1) begin
        state_d = cpu_core_pkg::ST_EXEC;
        case (pend_q)
          cpu_core_pkg::PEND_XRD: begin
            xd_re = 1'b1;
            acc_d = xd_rdata;
          end
          cpu_core_pkg::PEND_XWR: xd_we = 1'b1;
          cpu_core_pkg::PEND_TBL: acc_d = tbl_data;
          default: acc_d = acc_q;
        endcase
      end
    end
    if (mw_en && mw_dir && mw_addr[7]) begin
      case (mw_addr)
        cpu_core_pkg::SFR_ACC: acc_d = mw_val;
        cpu_core_pkg::SFR_B: b_d = mw_val;
        cpu_core_pkg::SFR_SP: sp_d = mw_val;
        cpu_core_pkg::SFR_DPL: data_pointer_pair_d[7:0] = mw_val;
        cpu_core_pkg::SFR_DPH: data_pointer_pair_d[15:8] = mw_val;
        cpu_core_pkg::SFR_PSW: begin
          fl_d.cy = mw_val[cpu_core_pkg::PSW_CY];
          fl_d.ac = mw_val[cpu_core_pkg::PSW_AC];
          fl_d.ov = mw_val[cpu_core_pkg::PSW_OV];
          rs_d = {mw_val[cpu_core_pkg::PSW_RS1], mw_val[cpu_core_pkg::PSW_RS0]};
        end
        default: acc_d = acc_d;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= cpu_core_pkg::ST_EXEC;
      pend_q <= cpu_core_pkg::PEND_NONE;
      pc_q <= 16'h0000;
      data_pointer_pair_q <= 16'h0000;
      tbl_q <= 16'h0000;
      acc_q <= cpu_core_pkg::RST_BYTE;
      b_q <= cpu_core_pkg::RST_BYTE;
      sp_q <= cpu_core_pkg::RST_SP;
      rs_q <= 2'b00;
      fl_q <= '0;
      cnt_q <= 4'h0;
    end else begin
      state_q <= state_d;
      pend_q <= pend_d;
      pc_q <= pc_d;
      data_pointer_pair_q <= data_pointer_pair_d;
      tbl_q <= tbl_d;
      acc_q <= acc_d;
      b_q <= b_d;
      sp_q <= sp_d;
      rs_q <= rs_d;
      fl_q <= fl_d;
      cnt_q <= cnt_d;
    end
  end

  // data memory holds no reset; software initialises it
  always_ff @(posedge clk) begin
    if (!sys_rst && mw_en && !(mw_dir && mw_addr[7])) begin
      iram[mw_addr] <= mw_val;
    end
  end

  assign code_addr = pc_q;
  assign tbl_addr = tbl_q;
  assign xd_addr = data_pointer_pair_q;
  assign xd_wdata = acc_q;
  assign insn_start = (state_q == cpu_core_pkg::ST_EXEC);
  assign acc_value = acc_q;
  assign psw_value = psw_word();

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_two;
    !insn_start ##1 insn_start;
  endsequence
  property p_mov_ptr;
    insn_start && op == cpu_core_pkg::OP_MOV_PTR_IMM |=> s_two ##0
      (data_pointer_pair_q == {$past(b1, 2), $past(b2, 2)} &&
       pc_q == $past(pc_q, 2) + 16'h0003 && fl_q == $past(fl_q, 2));
  endproperty
  a_mov_ptr: assert property (p_mov_ptr) else $error("pointer load");
  property p_mov_dd;
    insn_start && op == cpu_core_pkg::OP_MOV_D_D |=> s_two ##0
      (pc_q == $past(pc_q, 2) + 16'h0003 && fl_q == $past(fl_q, 2));
  endproperty
  a_mov_dd: assert property (p_mov_dd) else $error("dir move");
  property p_add_dir;
    insn_start && op == {cpu_core_pkg::OPH_ADD, cpu_core_pkg::LO_DIR} |=>
      insn_start && pc_q == $past(pc_q) + 16'h0002;
  endproperty
  a_add_dir: assert property (p_add_dir) else $error("add dir");
  property p_inc_ptr;
    insn_start && op == cpu_core_pkg::OP_INC_PTR |=> s_two ##0
      (data_pointer_pair_q == $past(data_pointer_pair_q, 2) + 16'h0001 && fl_q == $past(fl_q, 2));
  endproperty
  a_inc_ptr: assert property (p_inc_ptr) else $error("inc pointer");
  property p_mul;
    insn_start && op == cpu_core_pkg::OP_MUL |=> !insn_start [*3] ##1
      (insn_start && {b_q, acc_q} == $past(prod, 4));
  endproperty
  a_mul: assert property (p_mul) else $error("multiply");
  property p_movx_rd;
    insn_start && op == cpu_core_pkg::OP_MOVX_RD &&
      external_access_timing_field == 3'h0 |=> xd_re && !insn_start ##1
      (insn_start && acc_q == $past(xd_rdata));
  endproperty
  a_movx_rd: assert property (p_movx_rd) else $error("xdata read");
  property p_sjmp;
    insn_start && op == cpu_core_pkg::OP_SJMP |=> s_two ##0
      (pc_q == $past(pc_q, 2) + 16'h0002 + $past(rel_ext, 2));
  endproperty
  a_sjmp: assert property (p_sjmp) else $error("short jump");
  property p_mov_rn_a;
    insn_start && op[7:3] == {cpu_core_pkg::OPH_ST_A, 1'b1} |=>
      acc_q == $past(acc_q) && fl_q == $past(fl_q);
  endproperty
  a_mov_rn_a: assert property (p_mov_rn_a) else $error("reg move");
  property p_da;
    insn_start && op == cpu_core_pkg::OP_DA |=> insn_start && $stable(fl_q.ov);
  endproperty
  a_da: assert property (p_da) else $error("decimal adjust");
  property p_movc;
    insn_start && op == cpu_core_pkg::OP_MOVC_PTR |=> s_two ##0
      (acc_q == $past(tbl_data) && psw_value[cpu_core_pkg::PSW_P] == ^acc_q);
  endproperty
  a_movc: assert property (p_movc) else $error("table lookup");
endmodule
`default_nettype wire

// ---- code_xdata_model.sv ----
// Purpose: program and external data memory facing the core
// Assumes: reads are combinational, writes land on the clock edge
// Notes: idle read data is the inverse of the last value read
`default_nettype none
module code_xdata_model (
  // clock
  input wire logic clk,
  // program fetch and table lookup
  input wire logic [15:0] code_addr,
  output logic [7:0] code_byte0,
  output logic [7:0] code_byte1,
  output logic [7:0] code_byte2,
  input wire logic [15:0] tbl_addr,
  output logic [7:0] tbl_data,
  // external data
  input wire logic [15:0] xd_addr,
  input wire logic [7:0] xd_wdata,
  input wire logic xd_we,
  input wire logic xd_re,
  output logic [7:0] xd_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] rom [0:65535];
  logic [7:0] xram [0:65535];
  logic [7:0] last_q;
  initial begin
    for (int i = 0; i < 65536; i++) begin
      rom[i] = 8'h00;
      xram[i] = 8'h00;
    end
    last_q = 8'h00;
  end
  assign code_byte0 = rom[code_addr];
  assign code_byte1 = rom[code_addr + 16'h0001];
  assign code_byte2 = rom[code_addr + 16'h0002];
  assign tbl_data = rom[tbl_addr];
  // a released bus must not keep showing stale data
  assign xd_rdata = xd_re ? xram[xd_addr] : ~last_q;
  always @(posedge clk) begin
    if (xd_re) last_q <= xram[xd_addr];
    if (xd_we) xram[xd_addr] <= xd_wdata;
  end
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Purpose: runs a short program through the core and checks each step
// Assumes: program loaded into the memory model before reset release
// Notes: each step checks cycle count, next pc, accumulator and status
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] fld = 3'h0;
  logic [15:0] code_addr, tbl_addr, xd_addr;
  logic [7:0] b0, b1, b2, tbl_data, xd_wdata, xd_rdata, acc, psw;
  logic xd_we, xd_re, insn_start;
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [7:0] prog [0:35] = '{8'h75, 8'h30, 8'h48, 8'h85, 8'h30, 8'h31,
    8'h74, 8'h38, 8'h25, 8'h31, 8'hd4, 8'h24, 8'h94, 8'hd4, 8'h95, 8'h30,
    8'h75, 8'hf0, 8'h10, 8'ha4, 8'he5, 8'hf0, 8'h90, 8'h00, 8'h40, 8'hf0,
    8'ha3, 8'he0, 8'h93, 8'h83, 8'hf8, 8'h78, 8'h31, 8'he6, 8'h80,
    8'hfe};

  always #25 clk = ~clk;

  cpu_core DUT (.clk(clk), .sys_rst(sys_rst), .code_addr(code_addr),
    .code_byte0(b0), .code_byte1(b1), .code_byte2(b2),
    .tbl_addr(tbl_addr), .tbl_data(tbl_data), .xd_addr(xd_addr),
    .xd_wdata(xd_wdata), .xd_we(xd_we), .xd_re(xd_re),
    .xd_rdata(xd_rdata), .external_access_timing_field(fld),
    .insn_start(insn_start), .acc_value(acc), .psw_value(psw));

  code_xdata_model mem (.clk(clk), .code_addr(code_addr),
    .code_byte0(b0), .code_byte1(b1), .code_byte2(b2),
    .tbl_addr(tbl_addr), .tbl_data(tbl_data), .xd_addr(xd_addr),
    .xd_wdata(xd_wdata), .xd_we(xd_we), .xd_re(xd_re),
    .xd_rdata(xd_rdata));

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cmp8(input string what, input logic [7:0] got,
                      input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cmp16(input string what, input logic [15:0] got,
                       input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // run the current instruction to the next decode and check its effects
  task automatic step(input logic [7:0] cyc, input logic [15:0] pc,
                      input logic [7:0] a, input logic [7:0] st);
    logic [7:0] n;
    n = 8'h00;
    do begin
      @(posedge clk);
      #1 n = n + 8'h01;
    end while (insn_start !== 1'b1 && n < 8'h14);
    cmp8("cycles", n, cyc);
    cmp16("next pc", code_addr, pc);
    cmp8("acc", acc, a);
    cmp8("status", psw, st);
    $display("step done at pc %h", pc);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      $display("mismatch %0t run did not finish", $time);
      conclude();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    for (int i = 0; i < 36; i++)
      mem.rom[i] = prog[i];
    mem.rom[16'h009b] = 8'h07;
    mem.rom[16'h0025] = 8'hc1;
    mem.xram[16'h0041] = 8'h5a;
    repeat (18) @(posedge clk);
    #1 sys_rst = 1'b0;
    cmp16("reset pc", code_addr, 16'h0000);
    cmp8("reset acc", acc, 8'h00);
    cmp8("reset status", psw, 8'h00);
    step(8'h02, 16'h0003, 8'h00, 8'h00);
    step(8'h02, 16'h0006, 8'h00, 8'h00);
    step(8'h01, 16'h0008, 8'h38, 8'h01);
    step(8'h01, 16'h000a, 8'h80, 8'h45);
    step(8'h01, 16'h000b, 8'h86, 8'h45);
    step(8'h01, 16'h000d, 8'h1a, 8'h85);
    step(8'h01, 16'h000e, 8'h80, 8'hc5);
    step(8'h01, 16'h0010, 8'h37, 8'h45);
    step(8'h02, 16'h0013, 8'h37, 8'h45);
    step(8'h04, 16'h0014, 8'h70, 8'h45);
    step(8'h01, 16'h0016, 8'h03, 8'h44);
    step(8'h02, 16'h0019, 8'h03, 8'h44);
    fld = 3'h1;
    step(8'h03, 16'h001a, 8'h03, 8'h44);
    cmp8("xdata write", mem.xram[16'h0040], 8'h03);
    fld = 3'h0;
    step(8'h02, 16'h001b, 8'h03, 8'h44);
    step(8'h02, 16'h001c, 8'h5a, 8'h44);
    step(8'h02, 16'h001d, 8'h07, 8'h45);
    step(8'h02, 16'h001e, 8'hc1, 8'h45);
    step(8'h01, 16'h001f, 8'hc1, 8'h45);
    step(8'h01, 16'h0021, 8'hc1, 8'h45);
    step(8'h01, 16'h0022, 8'h48, 8'h44);
    step(8'h02, 16'h0022, 8'h48, 8'h44);
    step(8'h02, 16'h0022, 8'h48, 8'h44);
    conclude();
  end
endmodule
`default_nettype wire
